// ---- hw/hpsbc_consts.vh ----
// Constants for the hot plug slot bus control block
`ifndef HPSBC_CONSTS_VH
`define HPSBC_CONSTS_VH

// Register byte offsets
`define HPSBC_CTRL_OFS      8'h00
`define HPSBC_STAT_OFS      8'h04
`define HPSBC_CLKDIS_OFS    8'h08
`define HPSBC_FREQ_OFS      8'h0C
`define HPSBC_ADDR_W        8

// Control register fields
`define HPSBC_CTRL_ENABLE   0
`define HPSBC_CTRL_DISABLE  1
`define HPSBC_CTRL_FLTEN    2
`define HPSBC_CTRL_HPRST    3
`define HPSBC_CTRL_PLED     4
`define HPSBC_CTRL_ALED     5
`define HPSBC_CTRL_SLOT2    6

// Frequency register fields
`define HPSBC_FREQ_CMD      0
`define HPSBC_FREQ_BUSRST   1
`define HPSBC_FREQ_FAST     2

// Slot configuration strap codes
`define HPSBC_STRAP_NOGLUE  4'hF
`define HPSBC_STRAP_ONE     4'h9
`define HPSBC_STRAP_TWO     4'hA
`define HPSBC_STRAP_HPEN    3

// Stage timing, in microseconds, and clock rate
`define HPSBC_CLK_MHZ       100
`define HPSBC_PWR_US        100
`define HPSBC_CLK_US        100
`define HPSBC_BUS_US        100
`define HPSBC_PWR_CYC       (`HPSBC_PWR_US * `HPSBC_CLK_MHZ)
`define HPSBC_CLK_CYC       (`HPSBC_CLK_US * `HPSBC_CLK_MHZ)
`define HPSBC_BUS_CYC       (`HPSBC_BUS_US * `HPSBC_CLK_MHZ)

// Slot state machine
`define HPSBC_ST_OFF        3'h0
`define HPSBC_ST_PWR        3'h1
`define HPSBC_ST_CLK        3'h2
`define HPSBC_ST_BUS        3'h3
`define HPSBC_ST_ON         3'h4
`define HPSBC_ST_DOWN       3'h5

`endif

// ---- hw/hpsbc_top.v ----
// Hot plug slot bus control: parallel slot ports and one-slot bus grounding
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "hpsbc_consts.vh"

module hpsbc_top #(
    parameter PWR_CYC = `HPSBC_PWR_CYC,
    parameter CLK_CYC = `HPSBC_CLK_CYC,
    parameter BUS_CYC = `HPSBC_BUS_CYC
) (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    // Straps and power good
    input  wire [3:0]  SLOT_CONFIG_STRAP,
    input  wire        POWER_GOOD,
    // Slot status inputs, two slots, active low where named
    input  wire [1:0]  BUTTON_N,
    input  wire [1:0]  MRL_N,
    input  wire [1:0]  POWER_FAULT_N,
    input  wire [1:0]  PRESENT1_N,
    input  wire [1:0]  PRESENT2_N,
    input  wire [1:0]  PCIX_CAP1,
    input  wire [1:0]  PCIX_CAP2,
    input  wire [1:0]  CARD_FAST_CAPABLE,
    // Slot control outputs, two slots
    output wire [1:0]  SLOT_POWER_ON,
    output wire [1:0]  CLOCK_CONNECT_N,
    output wire [1:0]  BUS_CONNECT_N,
    output wire [1:0]  SLOT_RESET_CTL_N,
    output wire [1:0]  POWER_INDICATOR_N,
    output wire [1:0]  ATTENTION_INDICATOR_N,
    output wire        PARALLEL_MODE,
    output wire        NO_GLUE_MODE,
    // Single-slot pin buffer controls
    output wire        BUS_GROUND,
    output wire        CTRL_PRECHARGE,
    output wire        CTRL_RELEASE,
    output wire        WAKE_IRQ_RELEASE,
    output wire [6:0]  SLOT_CLOCK_GROUND,
    output wire [6:0]  SLOT_CLOCK_HIGH,
    output wire        SLOT_BUS_RESET_N,
    output wire        OUTBOUND_ABORT,
    // Fast capable pin, open drain
    output wire        BUS_FAST_CAPABLE_PIN_O,
    output wire        BUS_FAST_CAPABLE_PIN_OE
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture at power good rising edge
    reg  [3:0]  strap_q;
    reg         strap_done_q;
    reg         pg_q;
    wire        no_glue  = (strap_q == `HPSBC_STRAP_NOGLUE);
    wire        two_slot = (strap_q == `HPSBC_STRAP_TWO);
    // parallel only for one or two slots
    wire        parallel = no_glue || two_slot || (strap_q == `HPSBC_STRAP_ONE);
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            strap_q      <= 4'h0;
            strap_done_q <= 1'b0;
            pg_q         <= 1'b0;
        end else begin
            pg_q <= POWER_GOOD;
            // strap sampled at power good rising
            if (POWER_GOOD && !pg_q) begin
                strap_q      <= SLOT_CONFIG_STRAP;
                strap_done_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    reg  [7:0]  addr_q;
    reg         wr_q;
    reg  [6:0]  ctrl_q;
    reg  [5:0]  clkdis_q;
    reg  [2:0]  freq_q;
    reg  [31:0] rdata_q;
    wire        take  = HSEL && HREADY && HTRANS[1];
    wire        wr_en = wr_q;
    wire        hp_reset = wr_en && (addr_q == `HPSBC_CTRL_OFS) && HWDATA[`HPSBC_CTRL_HPRST];

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end else begin
            addr_q <= HADDR[7:0];
            wr_q   <= take && HWRITE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-slot state machines
    reg  [2:0]  st_q    [0:1];
    reg  [15:0] cnt_q   [0:1];
    reg  [1:0]  pwr_q;
    reg  [1:0]  clock_connect_n_q;
    reg  [1:0]  bus_connect_n_q;
    reg  [1:0]  rst_q;
    reg  [1:0]  pled_q;
    reg  [1:0]  aled_q;
    reg         pre_q;
    wire [1:0]  slot_used = {two_slot, parallel};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_slot
            wire fault = slot_used[g] && !POWER_FAULT_N[g] && ctrl_q[`HPSBC_CTRL_FLTEN];
            // Slot select travels with the written word
            wire sel   = (HWDATA[`HPSBC_CTRL_SLOT2] == (g == 1));
            wire en    = wr_en && (addr_q == `HPSBC_CTRL_OFS) && sel && slot_used[g]
                         && HWDATA[`HPSBC_CTRL_ENABLE];
            wire dis   = wr_en && (addr_q == `HPSBC_CTRL_OFS) && sel
                         && HWDATA[`HPSBC_CTRL_DISABLE];
            always @(posedge CLK or posedge RST) begin
                if (RST) begin
                    st_q[g]    <= `HPSBC_ST_OFF;
                    cnt_q[g]   <= 16'h0000;
                    pwr_q[g]   <= 1'b0;
                    clock_connect_n_q[g] <= 1'b0;
                    bus_connect_n_q[g] <= 1'b0;
                    rst_q[g]   <= 1'b0;
                    pled_q[g]  <= 1'b0;
                    aled_q[g]  <= 1'b0;
                end else if (hp_reset) begin
                    st_q[g]    <= `HPSBC_ST_OFF;
                    cnt_q[g]   <= 16'h0000;
                    pwr_q[g]   <= 1'b0;
                    clock_connect_n_q[g] <= 1'b0;
                    bus_connect_n_q[g] <= 1'b0;
                    rst_q[g]   <= 1'b0;
                    pled_q[g]  <= 1'b0;
                    aled_q[g]  <= 1'b0;
                // fault resets and isolates at once
                end else if (fault && st_q[g] != `HPSBC_ST_OFF) begin
                    rst_q[g]   <= 1'b0;
                    bus_connect_n_q[g] <= 1'b0;
                    clock_connect_n_q[g] <= 1'b0;
                    aled_q[g]  <= 1'b1;
                    st_q[g]    <= `HPSBC_ST_DOWN;
                    cnt_q[g]   <= 16'h0000;
                end else begin
                    if (wr_en && (addr_q == `HPSBC_CTRL_OFS) && sel) begin
                        pled_q[g] <= HWDATA[`HPSBC_CTRL_PLED];
                        aled_q[g] <= HWDATA[`HPSBC_CTRL_ALED];
                    end
                    case (st_q[g])
                        `HPSBC_ST_OFF: begin
                            if (en) begin
                                pwr_q[g] <= 1'b1;
                                cnt_q[g] <= 16'h0000;
                                st_q[g]  <= `HPSBC_ST_PWR;
                            end
                        end
                        `HPSBC_ST_PWR: begin
                            if (dis) begin
                                st_q[g] <= `HPSBC_ST_DOWN;
                            end else if (cnt_q[g] == PWR_CYC - 1) begin
                                clock_connect_n_q[g] <= 1'b1;
                                cnt_q[g]   <= 16'h0000;
                                st_q[g]    <= `HPSBC_ST_CLK;
                            end else begin
                                cnt_q[g] <= cnt_q[g] + 16'h0001;
                            end
                        end
                        `HPSBC_ST_CLK: begin
                            if (dis) begin
                                st_q[g] <= `HPSBC_ST_DOWN;
                            end else if (cnt_q[g] == CLK_CYC - 1) begin
                                bus_connect_n_q[g] <= 1'b1;
                                cnt_q[g]   <= 16'h0000;
                                st_q[g]    <= `HPSBC_ST_BUS;
                            end else begin
                                cnt_q[g] <= cnt_q[g] + 16'h0001;
                            end
                        end
                        `HPSBC_ST_BUS: begin
                            if (dis) begin
                                st_q[g] <= `HPSBC_ST_DOWN;
                            end else if (cnt_q[g] == BUS_CYC - 1) begin
                                rst_q[g] <= 1'b1;
                                st_q[g]  <= `HPSBC_ST_ON;
                            end else begin
                                cnt_q[g] <= cnt_q[g] + 16'h0001;
                            end
                        end
                        `HPSBC_ST_ON: begin
                            if (dis) begin
                                st_q[g] <= `HPSBC_ST_DOWN;
                            end
                        end
                        `HPSBC_ST_DOWN: begin
                            rst_q[g]   <= 1'b0;
                            bus_connect_n_q[g] <= !rst_q[g] ? 1'b0 : bus_connect_n_q[g];
                            clock_connect_n_q[g] <= !bus_connect_n_q[g] && !rst_q[g] ? 1'b0 : clock_connect_n_q[g];
                            if (!clock_connect_n_q[g] && !bus_connect_n_q[g] && !rst_q[g]) begin
                                pwr_q[g] <= 1'b0;
                                st_q[g]  <= `HPSBC_ST_OFF;
                            end
                        end
                        default: st_q[g] <= `HPSBC_ST_OFF;
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registers: control, clock disable and frequency
    reg         fast_q;
    reg         m66_gnd_q;
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q    <= 7'h00;
            clkdis_q  <= 6'h00;
            freq_q    <= 3'h0;
            fast_q    <= 1'b0;
            m66_gnd_q <= 1'b0;
        end else begin
            if (wr_en && addr_q == `HPSBC_CTRL_OFS) begin
                ctrl_q <= HWDATA[6:0];
            end
            if (wr_en && addr_q == `HPSBC_CLKDIS_OFS) begin
                clkdis_q <= HWDATA[5:0];
            end
            if (wr_en && addr_q == `HPSBC_FREQ_OFS) begin
                freq_q <= HWDATA[2:0];
            end
            // hot plug init starts at 33 MHz
            // ground pin on 33 MHz events
            if (POWER_GOOD && !pg_q && SLOT_CONFIG_STRAP[`HPSBC_STRAP_HPEN]) begin
                fast_q    <= 1'b0;
                m66_gnd_q <= 1'b1;
            end else if (wr_en && addr_q == `HPSBC_FREQ_OFS
                         && (HWDATA[`HPSBC_FREQ_CMD] || HWDATA[`HPSBC_FREQ_BUSRST])) begin
                fast_q    <= HWDATA[`HPSBC_FREQ_FAST];
                m66_gnd_q <= !HWDATA[`HPSBC_FREQ_FAST];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Single-slot pin buffer controls
    // three separate stage controls
    wire        ng_bus = bus_connect_n_q[0];
    wire        ng_clk = clock_connect_n_q[0];
    reg         bus_connect_n_d1_q;
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            bus_connect_n_d1_q <= 1'b0;
            pre_q      <= 1'b0;
        end else begin
            bus_connect_n_d1_q <= ng_bus;
            pre_q      <= no_glue && ng_bus && !bus_connect_n_d1_q;
        end
    end

    assign BUS_GROUND       = no_glue && !ng_bus;
    assign CTRL_PRECHARGE   = pre_q;
    assign CTRL_RELEASE     = no_glue && bus_connect_n_d1_q && !pre_q;
    assign WAKE_IRQ_RELEASE = no_glue && ng_bus;
    // clocks 5..0 ground if enabled, 6 never
    assign SLOT_CLOCK_GROUND = {1'b0, (no_glue && !ng_clk) ? ~clkdis_q : 6'h00};
    assign SLOT_CLOCK_HIGH  = {1'b0, clkdis_q};
    // reset stays low until final stage
    assign SLOT_BUS_RESET_N = rst_q[0];
    assign OUTBOUND_ABORT   = no_glue && !ng_bus;

    // pin grounded only serial or two-slot
    // never driven in the one-slot modes
    assign BUS_FAST_CAPABLE_PIN_O  = 1'b0;
    assign BUS_FAST_CAPABLE_PIN_OE = m66_gnd_q && strap_done_q
                                     && (two_slot || !parallel);

    ////////////////////////////////////////////////////////////////////////
    // Slot outputs
    // six outputs per slot
    assign SLOT_POWER_ON         = pwr_q;
    assign CLOCK_CONNECT_N       = ~clock_connect_n_q;
    assign BUS_CONNECT_N         = ~bus_connect_n_q;
    assign SLOT_RESET_CTL_N      = rst_q;
    assign POWER_INDICATOR_N     = ~pled_q;
    assign ATTENTION_INDICATOR_N = ~aled_q;
    assign PARALLEL_MODE         = parallel;
    assign NO_GLUE_MODE          = no_glue;

    ////////////////////////////////////////////////////////////////////////
    // Read data
    reg  [31:0] rd_d;
    always @* begin
        case (HADDR[7:0])
            `HPSBC_CTRL_OFS:   rd_d = {25'h0, ctrl_q};
            `HPSBC_STAT_OFS:   rd_d = {12'h000, st_q[1], st_q[0], CARD_FAST_CAPABLE & slot_used,
                                       PCIX_CAP2, PCIX_CAP1, PRESENT2_N, PRESENT1_N,
                                       MRL_N, BUTTON_N};
            `HPSBC_CLKDIS_OFS: rd_d = {26'h0, clkdis_q};
            `HPSBC_FREQ_OFS:   rd_d = {28'h0, fast_q, freq_q};
            default:           rd_d = 32'h0;
        endcase
    end
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= 32'h0;
        end else if (take && !HWRITE) begin
            rdata_q <= rd_d;
        end
    end

    assign HRDATA    = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

endmodule // hpsbc_top

// ---- tb/hpsbc_monitor.sv ----
// Port checker for the hot plug slot bus control
`timescale 1ns/100ps
module hpsbc_monitor #(
    parameter PWR_CYC = 10000
) (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    // Slot controls
    input wire logic [1:0] SLOT_POWER_ON,
    input wire logic [1:0] CLOCK_CONNECT_N,
    input wire logic [1:0] BUS_CONNECT_N,
    input wire logic [1:0] SLOT_RESET_CTL_N,
    input wire logic       NO_GLUE_MODE,
    // Pin buffer controls
    input wire logic       BUS_GROUND,
    input wire logic       CTRL_PRECHARGE,
    input wire logic       CTRL_RELEASE,
    input wire logic [6:0] SLOT_CLOCK_GROUND,
    input wire logic [6:0] SLOT_CLOCK_HIGH,
    input wire logic       SLOT_BUS_RESET_N,
    input wire logic       OUTBOUND_ABORT,
    input wire logic       BUS_FAST_CAPABLE_PIN_OE
);
    logic [15:0] wait_q;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////
    // Cycles spent powered before the clock joins
    always @(posedge CLK or posedge RST) begin
        if (RST)
            wait_q <= 16'h0;
        else if (SLOT_POWER_ON[0] && CLOCK_CONNECT_N[0])
            wait_q <= wait_q + 16'h1;
        else
            wait_q <= 16'h0;
    end
    ////////////////////////////////////////////////////////////
    clk6_never_a: assert property (!SLOT_CLOCK_GROUND[6])
        else $error("feedback clock grounded");
    clk_levels_a: assert property ((SLOT_CLOCK_GROUND & SLOT_CLOCK_HIGH) == 7'h00)
        else $error("clock both grounded and high");
    gnd_disc_a: assert property (NO_GLUE_MODE && $past(NO_GLUE_MODE) && BUS_CONNECT_N[0]
        && $past(BUS_CONNECT_N[0]) |-> BUS_GROUND) else $error("bus not grounded");
    abort_gnd_a: assert property (OUTBOUND_ABORT == (NO_GLUE_MODE && BUS_CONNECT_N[0]))
        else $error("outbound not aborted");
    fast_nodrive_a: assert property (NO_GLUE_MODE |-> !BUS_FAST_CAPABLE_PIN_OE)
        else $error("fast pin driven in one slot");
    power_first_a: assert property ($rose(SLOT_POWER_ON[0]) |-> CLOCK_CONNECT_N[0]
        && !SLOT_RESET_CTL_N[0] && BUS_GROUND == NO_GLUE_MODE) else $error("power not first");
    stage_min_a: assert property ($fell(CLOCK_CONNECT_N[0]) |-> wait_q >= PWR_CYC - 2)
        else $error("clock joined early");
    bus_rst_low_a: assert property ($fell(BUS_GROUND) |-> !SLOT_BUS_RESET_N [*2])
        else $error("reset released with bus");
    precharge_a: assert property (CTRL_PRECHARGE |=> !CTRL_PRECHARGE && CTRL_RELEASE)
        else $error("precharge not one clock");
    power_last_a: assert property ($fell(SLOT_POWER_ON[0]) |-> CLOCK_CONNECT_N[0]
        && BUS_CONNECT_N[0]) else $error("power removed too soon");
    cover property ($rose(SLOT_BUS_RESET_N));
    cover property (CTRL_PRECHARGE);
    cover property ($fell(SLOT_POWER_ON[0]));
endmodule // hpsbc_monitor

bind hpsbc_top hpsbc_monitor #(.PWR_CYC(PWR_CYC)) i_monitor (.*);

// ---- tb/hpsbc_slot_model.sv ----
// Slot, card and power controller model for the hot plug slot bus control
`timescale 1ns/100ps
module hpsbc_slot_model (
    // From bridge and bench
    input  wire logic [1:0] slot_power_on,
    input  wire logic       card_in,
    input  wire logic       fault_req,
    // Status to bridge
    output wire logic [1:0] button_n,
    output wire logic [1:0] mrl_n,
    output wire logic [1:0] fault_n,
    output wire logic [1:0] prs1_n,
    output wire logic [1:0] prs2_n,
    output wire logic [1:0] cap1,
    output wire logic [1:0] cap2,
    output wire logic [1:0] fast_cap
);
    assign button_n = 2'h3;
    assign mrl_n    = {1'h0, ~card_in};
    assign fault_n  = {1'h1, ~(fault_req & slot_power_on[0])};
    assign prs1_n   = {1'h1, ~card_in};
    assign prs2_n   = 2'h3;
    assign cap1     = {1'h0, card_in};
    assign cap2     = 2'h0;
    // Pulled up to the slot rail only
    assign fast_cap = {1'h0, slot_power_on[0] & card_in};
endmodule // hpsbc_slot_model

// ---- tb/hpsbc_bench.sv ----
// Self-checking bench for the hot plug slot bus control
`timescale 1ns/100ps
`include "hpsbc_consts.vh"
module hpsbc_bench;
    localparam int STG = 4;
    logic        CLK = 1'h0, RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0, POWER_GOOD = 1'h0;
    logic        card_in = 1'h0, fault_req = 1'h0, HREADY;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h2;
    logic [3:0]  SLOT_CONFIG_STRAP = 4'hF;
    logic        HREADYOUT, HRESP, PARALLEL_MODE, NO_GLUE_MODE, BUS_GROUND, CTRL_PRECHARGE;
    logic        CTRL_RELEASE, WAKE_IRQ_RELEASE, SLOT_BUS_RESET_N, OUTBOUND_ABORT;
    logic        BUS_FAST_CAPABLE_PIN_O, BUS_FAST_CAPABLE_PIN_OE;
    logic [1:0]  BUTTON_N, MRL_N, POWER_FAULT_N, PRESENT1_N, PRESENT2_N, PCIX_CAP1;
    logic [1:0]  PCIX_CAP2, CARD_FAST_CAPABLE, SLOT_POWER_ON, CLOCK_CONNECT_N, BUS_CONNECT_N;
    logic [1:0]  SLOT_RESET_CTL_N, POWER_INDICATOR_N, ATTENTION_INDICATOR_N;
    logic [6:0]  SLOT_CLOCK_GROUND, SLOT_CLOCK_HIGH;
    int          n_mismatch = 0, compares = 0, cyc = 0;
    ////////////////////////////////////////////////////////////
    assign HREADY = HREADYOUT;
    hpsbc_top #(.PWR_CYC(STG), .CLK_CYC(STG), .BUS_CYC(STG)) i_dut (.*);
    hpsbc_slot_model i_slot (
        .slot_power_on (SLOT_POWER_ON), .card_in (card_in), .fault_req (fault_req),
        .button_n (BUTTON_N), .mrl_n (MRL_N), .fault_n (POWER_FAULT_N),
        .prs1_n (PRESENT1_N), .prs2_n (PRESENT2_N), .cap1 (PCIX_CAP1),
        .cap2 (PCIX_CAP2), .fast_cap (CARD_FAST_CAPABLE)
    );
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {24'h0, a};
        @(posedge CLK);
        while (HREADY !== 1'h1) @(posedge CLK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADY !== 1'h1) @(posedge CLK);
        rd = HRDATA;
    endtask
    task automatic set_strap(input logic [3:0] s);
        RST <= 1'h1;
        POWER_GOOD <= 1'h0;
        SLOT_CONFIG_STRAP <= s;
        repeat (20) @(posedge CLK);
        RST <= 1'h0;
        repeat (2) @(posedge CLK);
        POWER_GOOD <= 1'h1;
        repeat (3) @(posedge CLK);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_modes();
        logic [3:0] codes [4] = '{4'h9, 4'hA, 4'hB, 4'hF};
        for (int i = 0; i < 4; i++) begin
            set_strap(codes[i]);
            chk({PARALLEL_MODE, NO_GLUE_MODE}, {codes[i] != 4'hB, codes[i] == 4'hF});
            chk({BUS_FAST_CAPABLE_PIN_OE, BUS_FAST_CAPABLE_PIN_O},
                {(codes[i] inside {4'hA, 4'hB}), 1'h0}); // pin
            chk({SLOT_POWER_ON, CLOCK_CONNECT_N, BUS_CONNECT_N, SLOT_RESET_CTL_N}, 8'h3C);
            chk({POWER_INDICATOR_N, ATTENTION_INDICATOR_N, HRESP, HREADYOUT}, 6'h3D); // lamps off
            bus(1'h1, `HPSBC_FREQ_OFS, 32'h1); // firmware setup
            bus(1'h1, `HPSBC_CTRL_OFS, 32'h41);
            repeat (3) @(posedge CLK);
            if (codes[i] != 4'hB) chk(SLOT_POWER_ON[1], codes[i] == 4'hA); // slot two
            if (codes[i] == 4'hA) begin
                bus(1'h1, `HPSBC_FREQ_OFS, 32'h5); // fast command
                bus(1'h0, `HPSBC_FREQ_OFS, 32'h0);
                chk({rd[3:0], BUS_FAST_CAPABLE_PIN_OE}, 5'h1A); // pin released
                bus(1'h1, `HPSBC_FREQ_OFS, 32'h1);
                @(posedge CLK);
                chk(BUS_FAST_CAPABLE_PIN_OE, 1'h1); // 33 MHz command
            end
        end
        $display("test modes done");
    endtask
    task automatic t_connect();
        int n;
        bus(1'h1, `HPSBC_CLKDIS_OFS, 32'h1);
        bus(1'h0, `HPSBC_CLKDIS_OFS, 32'h0);
        chk(rd[5:0], 6'h01);
        bus(1'h1, 8'h10, 32'hFFFF);
        bus(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk({BUS_GROUND, OUTBOUND_ABORT, BUS_FAST_CAPABLE_PIN_OE}, 3'h6);
        chk({SLOT_CLOCK_GROUND, SLOT_CLOCK_HIGH}, {7'h3E, 7'h01}); // clock levels
        card_in <= 1'h1;
        bus(1'h1, `HPSBC_CTRL_OFS, 32'h1);
        for (n = 0; n < 20 && SLOT_POWER_ON[0] !== 1'h1; n++) @(posedge CLK);
        chk({BUS_GROUND, SLOT_CLOCK_GROUND}, 8'hBE); // still grounded
        for (n = 0; n < 40 && CLOCK_CONNECT_N[0] !== 1'h0; n++) @(posedge CLK);
        chk(n >= STG - 1 && n <= STG + 3, 1'h1); // stage wait
        @(posedge CLK);
        chk({BUS_GROUND, SLOT_CLOCK_GROUND}, 8'h80); // clock alone
        for (n = 0; n < 40 && CTRL_PRECHARGE !== 1'h1; n++) @(posedge CLK);
        chk({CTRL_PRECHARGE, BUS_GROUND, SLOT_BUS_RESET_N}, 3'h4); // bus joined
        @(posedge CLK);
        chk({CTRL_PRECHARGE, CTRL_RELEASE, WAKE_IRQ_RELEASE}, 3'h3); // released
        for (n = 0; n < 40 && SLOT_BUS_RESET_N !== 1'h1; n++) @(posedge CLK);
        @(posedge CLK);
        chk({SLOT_BUS_RESET_N, OUTBOUND_ABORT, BUS_FAST_CAPABLE_PIN_OE}, 3'h4);
        bus(1'h0, `HPSBC_STAT_OFS, 32'h0);
        chk(rd & 32'h1555, 32'h1141);
        $display("test connect done");
    endtask
    task automatic t_disconnect();
        int tr = 99, tb = 99, tc = 99, tp = 99;
        bus(1'h1, `HPSBC_CTRL_OFS, 32'h2);
        for (int n = 0; n < 20; n++) begin
            @(posedge CLK);
            if (SLOT_RESET_CTL_N[0] === 1'h0 && tr > n) tr = n;
            if (BUS_CONNECT_N[0] === 1'h1 && tb > n) tb = n;
            if (CLOCK_CONNECT_N[0] === 1'h1 && tc > n) tc = n;
            if (SLOT_POWER_ON[0] === 1'h0 && tp > n) tp = n;
        end
        chk(tr < tb && tb < tc && tc < tp && tp < 99, 1'h1); // teardown order
        chk({BUS_GROUND, OUTBOUND_ABORT, SLOT_CLOCK_GROUND}, 9'h1BE); // regrounded
        $display("test disconnect done");
    endtask
    task automatic t_fault();
        int n;
        bus(1'h1, `HPSBC_CTRL_OFS, 32'h5);
        for (n = 0; n < 60 && SLOT_BUS_RESET_N !== 1'h1; n++) @(posedge CLK);
        fault_req <= 1'h1;
        repeat (2) @(posedge CLK);
        chk({SLOT_RESET_CTL_N[0], BUS_CONNECT_N[0], CLOCK_CONNECT_N[0],
             ATTENTION_INDICATOR_N[0]}, 4'h6); // fault cut
        fault_req <= 1'h0;
        $display("test fault done");
    endtask
    task automatic t_ctrl_reset();
        bus(1'h1, `HPSBC_CTRL_OFS, 32'h34);
        repeat (2) @(posedge CLK);
        chk({POWER_INDICATOR_N[0], ATTENTION_INDICATOR_N[0]}, 2'h0);
        bus(1'h1, `HPSBC_CTRL_OFS, 32'h8);
        repeat (2) @(posedge CLK);
        chk({SLOT_POWER_ON, CLOCK_CONNECT_N, BUS_CONNECT_N, SLOT_RESET_CTL_N}, 8'h3C);
        chk({POWER_INDICATOR_N, ATTENTION_INDICATOR_N, BUS_GROUND}, 5'h1F); // lamps
        $display("test controller reset done");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        t_modes();
        t_connect();
        t_disconnect();
        t_fault();
        t_ctrl_reset();
        tally_and_finish();
    end
endmodule // hpsbc_bench
